/* File: bench/i2cm_slave_model.sv */
`timescale 1ns/1ns
module i2cm_slave_model (
    // wire levels
    input wire logic       scl,
    input wire logic       sda,
    // behaviour selection
    input wire logic       ack_en,
    input wire logic       rd_mode,
    input wire logic       hold_low,
    input wire logic [7:0] tx_byte,
    // pull-down and captured byte
    output logic           sda_oe,
    output logic [7:0]     rx_byte
);
    int cnt = 0;
    // start resets slot count
    always @(negedge sda) if (scl) cnt = 0;
    // capture msb first on rising clock
    always @(posedge scl) if (!rd_mode && cnt > 0 && cnt < 9) rx_byte = {rx_byte[6:0], sda};
    // falling clock advances slot; 9 is ack in write mode, read mode wraps after 8
    always @(negedge scl) cnt = (cnt == (rd_mode ? 8 : 9)) ? 1 : cnt + 1;
    // pull low: forced, ack or read zero
    assign sda_oe = hold_low | (!rd_mode && ack_en && cnt == 9)
                  | (rd_mode && cnt > 0 && cnt < 9 && !tx_byte[8-cnt]);
endmodule // i2cm_slave_model

/* File: bench/i2cm_top_sva.sv */
`timescale 1ns/1ns
module i2cm_top_sva
    import i2cm_pkg::*;
(
    // clock and reset
    input wire logic              core_clk,
    input wire logic              sys_rst,
    // software side
    input wire i2cm_buf_wr_t      buf_wr,
    input wire i2cm_ctrl_wr_t     ctrl2_wr,
    input wire i2cm_flags_t       flag_clear,
    // status and pins
    input wire logic [7:0]        control_register_2,
    input wire logic [7:0]        status_register,
    input wire logic [BYTE_W-1:0] transfer_buffer,
    input wire i2cm_flags_t       flags,
    input wire logic              rx_valid,
    input wire logic              sda_in,
    input wire logic              scl_in,
    input wire logic              sda_oe,
    input wire logic              scl_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // sequence ends
    property p_start_hold;
        $fell(control_register_2[0]) && !flags.bus_collision_flag |-> sda_oe;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start hold");
    property p_restart_end;
        $fell(control_register_2[1]) && !flags.bus_collision_flag |-> sda_oe && !scl_oe;
    endproperty
    a_restart_end: assert property (p_restart_end) else $error("restart end");
    property p_start_seen;
        $fell(sda_in) && scl_in |-> ##[1:6] status_register[3];
    endproperty
    a_start_seen: assert property (p_start_seen) else $error("start missed");
    // start locks
    property p_write_collision_start;
        buf_wr.valid && control_register_2[0] |=> flags.write_collision && $stable(transfer_buffer);
    endproperty
    a_write_collision_start: assert property (p_write_collision_start) else $error("write_collision start");
    property p_ctrl_locked;
        ctrl2_wr.valid && control_register_2[0] && !control_register_2[3] |=> !control_register_2[3];
    endproperty
    a_ctrl_locked: assert property (p_ctrl_locked) else $error("ctrl locked");
    // sticky flags, overflow only when full
    property p_write_collision_sticky;
        flags.write_collision && !flag_clear.write_collision |=> flags.write_collision;
    endproperty
    a_write_collision_sticky: assert property (p_write_collision_sticky) else $error("write_collision lost");
    property p_irq_sticky;
        flags.module_interrupt_flag && !flag_clear.module_interrupt_flag |=> flags.module_interrupt_flag;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq lost");
    property p_ovf_full;
        $rose(flags.receive_overflow) |-> status_register[0];
    endproperty
    a_ovf_full: assert property (p_ovf_full) else $error("ovf not full");
    // scenarios
    c_rx: cover property ($rose(rx_valid));
    c_bcl: cover property ($rose(flags.bus_collision_flag));
    c_write_collision: cover property ($rose(flags.write_collision));
endmodule // i2cm_top_sva

bind i2cm_top i2cm_top_sva u_i2cm_top_sva (.*);

/* File: bench/i2cm_top_tb.sv */
`timescale 1ns/1ns
module i2cm_top_tb
    import i2cm_pkg::*;
;
    logic          core_clk = 1'b0, sys_rst, rx_ready, ack_en, rd_mode, hold_low;
    logic          rx_valid, sda_oe, scl_oe, slv_oe;
    logic [7:0]    cr2, stat, tbuf, rx_data, rx_byte, tx_byte;
    i2cm_buf_wr_t  buf_wr;
    i2cm_ctrl_wr_t ctrl2_wr;
    i2cm_flags_t   flag_clear, flags;
    int            fails = 0, check_count = 0, cycles = 0;
    // open-drain wires with pull-ups
    wire sda = !(sda_oe | slv_oe);
    wire scl = !scl_oe;
    always #25 core_clk = ~core_clk;
    i2cm_top u_i2cm_top (.core_clk(core_clk), .sys_rst(sys_rst), .buf_wr(buf_wr),
        .ctrl2_wr(ctrl2_wr), .flag_clear(flag_clear), .baud_reload_register(8'h01),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .control_register_2(cr2),
        .status_register(stat), .transfer_buffer(tbuf), .flags(flags), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .scl_in(scl), .scl_out(), .scl_oe(scl_oe));
    i2cm_slave_model u_i2cm_slave_model (.scl(scl), .sda(sda), .ack_en(ack_en),
        .rd_mode(rd_mode), .hold_low(hold_low), .tx_byte(tx_byte), .sda_oe(slv_oe),
        .rx_byte(rx_byte));
    // verdict
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one-cycle strobes at falling edge
    task automatic ctrl(input logic [4:0] d);
        @(negedge core_clk) ctrl2_wr = {1'b1, d};
        @(negedge core_clk) ctrl2_wr = '0;
    endtask
    task automatic bw(input logic [7:0] d);
        @(negedge core_clk) buf_wr = {1'b1, d};
        @(negedge core_clk) buf_wr = '0;
    endtask
    task automatic clr(input i2cm_flags_t f);
        @(negedge core_clk) flag_clear = f;
        @(negedge core_clk) flag_clear = '0;
    endtask
    // wait for interrupt, clear it
    task automatic wait_irq;
        int n;
        n = 0;
        while (flags.module_interrupt_flag !== 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        check("interrupt", 8'h01, 8'(flags.module_interrupt_flag));
        clr(4'h2);
    endtask
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run;
        end
    end
    // test sequence
    initial begin
        {sys_rst, rx_ready, ack_en, rd_mode, hold_low} = 5'h10;
        {buf_wr, ctrl2_wr, flag_clear} = '0;
        tx_byte = 8'h96;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        hold_low = 1'b1;
        repeat (4) @(negedge core_clk);
        ctrl(5'h01);
        check("collision", 8'h01, 8'(flags.bus_collision_flag));
        check("start req", 8'h00, 8'(cr2[0]));
        clr(4'h1);
        hold_low = 1'b0;
        repeat (4) @(negedge core_clk);
        $display("bcl done");
        ctrl(5'h01);
        bw(8'h11);
        ctrl(5'h08);
        wait_irq;
        check("ctrl2", 8'h00, cr2);
        check("start seen", 8'h01, 8'(stat[3]));
        check("write_collision", 8'h01, 8'(flags.write_collision));
        check("buffer", 8'h00, tbuf);
        clr(4'h8);
        $display("start done");
        ack_en = 1'b1;
        bw(8'hA5);
        ctrl(5'h02);
        check("full", 8'h01, 8'(stat[0]));
        check("restart req", 8'h00, 8'(cr2[1]));
        repeat (16) @(negedge core_clk);
        bw(8'h3C);
        check("buffer", 8'hA5, tbuf);
        wait_irq;
        check("ack", 8'h00, 8'(cr2[6]));
        check("full", 8'h00, 8'(stat[0]));
        check("sent", 8'hA5, rx_byte);
        check("scl held", 8'h01, 8'(scl_oe));
        ack_en = 1'b0;
        bw(8'h5A);
        bw(8'h5B);
        check("buffer", 8'h5B, tbuf);
        check("write_collision", 8'h01, 8'(flags.write_collision));
        wait_irq;
        check("nack", 8'h01, 8'(cr2[6]));
        clr(4'h8);
        $display("tx done");
        ctrl(5'h02);
        wait_irq;
        check("restart lines", 8'h02, {6'h00, sda_oe, scl_oe});
        $display("rs done");
        rd_mode = 1'b1;
        ctrl(5'h08);
        wait_irq;
        check("rx data", 8'h96, rx_data);
        check("rx state", 8'h41, {cr2[3], stat[0], 5'h00, rx_valid});
        ctrl(5'h08);
        wait_irq;
        check("overflow", 8'h01, 8'(flags.receive_overflow));
        @(negedge core_clk) rx_ready = 1'b1;
        repeat (2) @(negedge core_clk);
        rx_ready = 1'b0;
        check("full", 8'h00, 8'(stat[0]));
        $display("rx done");
        complete_run;
    end
endmodule // i2cm_top_tb

/* File: verilog/i2cm_pkg.sv */
package i2cm_pkg;
    // clock and instruction-cycle timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int TCY_NS         = 200;
    localparam int TCY_CYC        = TCY_NS / CLK_PERIOD_NS;
    localparam int BAUD_STEP_CYC  = TCY_CYC / 2;
    localparam int WRITE_COLLISION_WIN_TCY   = 2;
    localparam int WRITE_COLLISION_WIN_CYC   = WRITE_COLLISION_WIN_TCY * TCY_CYC;
    // widths and depths
    localparam int BYTE_W         = 8;
    localparam int FIFO_DEPTH     = 4;
    localparam int LAST_TX_BIT    = 8;
    localparam int LAST_DATA_BIT  = 7;
    // control_register_2 fields
    localparam int CTRL2_START_BIT  = 0;
    localparam int CTRL2_RSTART_BIT = 1;
    localparam int CTRL2_RCV_BIT    = 3;
    localparam int CTRL2_ACKST_BIT  = 6;
    localparam int CTRL2_WR_W       = 5;
    // status_register fields
    localparam int STAT_BF_BIT      = 0;
    localparam int STAT_START_BIT   = 3;
    // reset values
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] STAT_RST  = 8'h00;
    localparam logic [7:0] BUF_RST   = 8'h00;

    typedef enum logic [3:0] {
        I2CM_IDLE, I2CM_ST_WAIT, I2CM_ST_HOLD,
        I2CM_RS_SCL_LOW, I2CM_RS_SDA_REL, I2CM_RS_RISE, I2CM_RS_HIGH, I2CM_RS_SDA_LOW,
        I2CM_TX_LOW, I2CM_TX_RISE, I2CM_TX_HIGH,
        I2CM_RX_LOW, I2CM_RX_RISE, I2CM_RX_HIGH, I2CM_RX_PUSH
    } i2cm_state_t;

    // sticky flags, also used as the software clear strobes
    typedef struct packed {
        logic write_collision;
        logic receive_overflow;
        logic module_interrupt_flag;
        logic bus_collision_flag;
    } i2cm_flags_t;

    // software write to transfer_buffer
    typedef struct packed {
        logic              valid;
        logic [BYTE_W-1:0] data;
    } i2cm_buf_wr_t;

    // software write to the low bits of control_register_2
    typedef struct packed {
        logic                  valid;
        logic [CTRL2_WR_W-1:0] data;
    } i2cm_ctrl_wr_t;
endpackage

/* File: verilog/i2cm_top.sv */
// Functional notes
// (R1) start: load baud, then data low
// (R2) start seen sets status bit
// (R3) hold period, clear start request
// (R4) start on busy lines: collision, idle
// (R5) buffer write in start/receive: collision
// (R6) control writes locked while busy
// (R7) restart: clock low, data released
// (R8) restart: high period, data low
// (R9) restart interrupt after final timeout
// (R10) restart request needs idle
// (R11) restart collision: data or clock low
// (R12) transmit write sets buffer full
// (R13) one period low, one high per bit
// (R14) eighth fall clears full, frees data
// (R15) ninth fall samples acknowledge
// (R16) after ninth: interrupt, suspend, clock low
// (R17) write while shifting: collision, early update
// (R18) write collision cleared by software only
// (R19) receive enable honoured only when idle
// (R20) receive: clock per rollover, shift data
// (R21) eighth receive fall: buffer, interrupt
// (R22) overflow when byte meets full buffer
// (R23) two counter steps per instruction cycle
// (R24) interrupt, collision flags software-cleared
`timescale 1ns/1ns

module i2cm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    wire [PW-1:0]     wr_nxt = (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
    wire [PW-1:0]     rd_nxt = (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
    wire [PW-1:0]     head_idx = pop ? rd_nxt : rd_ptr;
    wire [PW:0]       next_count = count + (PW+1)'(push) - (PW+1)'(pop);
    // head of queue after this edge; bypass when the new word is the only one
    wire [WIDTH-1:0]  next_head = (push && head_idx == wr_ptr) ? in_data : mem[head_idx];

    // storage writes
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // registered flags and head word
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_ptr    <= push ? wr_nxt : wr_ptr;
            rd_ptr    <= pop ? rd_nxt : rd_ptr;
            count     <= next_count;
            in_ready  <= next_count != FULL_CNT;
            out_valid <= next_count != '0;
            out_data  <= next_head;
        end
    end
endmodule // i2cm_fifo

module i2cm_top
    import i2cm_pkg::*;
(
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    // software access
    input  wire i2cm_buf_wr_t    buf_wr,
    input  wire i2cm_ctrl_wr_t   ctrl2_wr,
    input  wire i2cm_flags_t     flag_clear,
    input  wire logic [7:0]      baud_reload_register,
    // received byte stream
    output logic                 rx_valid,
    input  wire logic            rx_ready,
    output logic [BYTE_W-1:0]    rx_data,
    // status
    output logic [7:0]           control_register_2,
    output logic [7:0]           status_register,
    output logic [BYTE_W-1:0]    transfer_buffer,
    output i2cm_flags_t          flags,
    // bus pins (open drain)
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe,
    input  wire logic            scl_in,
    output logic                 scl_out,
    output logic                 scl_oe
);
    i2cm_state_t       state;
    logic [6:0]        baud_counter;
    logic [1:0]        step_cnt;
    logic [3:0]        bit_idx;
    logic [BYTE_W-1:0] shift_register;
    logic [3:0]        wr_age;
    logic              push_valid;
    logic              fifo_in_ready;
    logic [1:0]        sync1;
    logic [1:0]        sync2;
    logic [1:0]        sync3;
    logic [1:0]        line_f;
    logic              sda_prev;
    logic              scl_prev;

    // three-stage pin filters
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                sync1[i]  <= 1'b1;
                sync2[i]  <= 1'b1;
                sync3[i]  <= 1'b1;
                line_f[i] <= 1'b1;
            end else begin
                sync1[i]  <= (i == 0) ? sda_in : scl_in;
                sync2[i]  <= sync1[i];
                sync3[i]  <= sync2[i];
                line_f[i] <= (sync2[i] == sync3[i]) ? sync3[i] : line_f[i];
            end
        end
    end

    // line and counter events
    wire       sda_f    = line_f[0];
    wire       scl_f    = line_f[1];
    wire       step_hit = step_cnt == 2'(BAUD_STEP_CYC - 1);
    wire       timeout  = step_hit && baud_counter == 7'h00;
    wire [6:0] load_hi  = baud_reload_register[6:0];
    wire [6:0] load_lo  = {1'b0, baud_reload_register[5:0]};
    wire       idle     = state == I2CM_IDLE;
    wire       in_start = state inside {I2CM_ST_WAIT, I2CM_ST_HOLD};
    wire       in_rs    = state inside {I2CM_RS_SCL_LOW, I2CM_RS_SDA_REL, I2CM_RS_RISE,
                                        I2CM_RS_HIGH, I2CM_RS_SDA_LOW};
    wire       in_tx    = state inside {I2CM_TX_LOW, I2CM_TX_RISE, I2CM_TX_HIGH};
    wire       in_rx    = state inside {I2CM_RX_LOW, I2CM_RX_RISE, I2CM_RX_HIGH,
                                        I2CM_RX_PUSH};
    wire       start_ev = sda_prev && !sda_f && scl_prev && scl_f;
    wire       ctl_ok   = ctrl2_wr.valid && idle;                          // [R6]
    wire       tx_bit   = transfer_buffer[3'(LAST_DATA_BIT) - bit_idx[2:0]];
    wire       bf       = status_register[STAT_BF_BIT];
    wire       cpu_read = rx_valid && rx_ready;
    wire       early_wr = wr_age < 4'(WRITE_COLLISION_WIN_CYC);

    // prescaler
    always_ff @(posedge core_clk) begin
        if (sys_rst || idle) begin
            step_cnt <= 2'h0;
        end else begin
            step_cnt <= step_hit ? 2'h0 : step_cnt + 2'h1;                 // [R23]
        end
    end

    // age of last buffer write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_age <= 4'(WRITE_COLLISION_WIN_CYC);
        end else if (buf_wr.valid && (idle || (in_tx && early_wr))) begin
            wr_age <= 4'h0;
        end else if (early_wr) begin
            wr_age <= wr_age + 4'h1;
        end
    end

    // line history for start detection
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sda_prev <= 1'b1;
            scl_prev <= 1'b1;
        end else begin
            sda_prev <= sda_f;
            scl_prev <= scl_f;
        end
    end

    // master sequencer; clears come first so a set in the same cycle wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state              <= I2CM_IDLE;
            baud_counter       <= 7'h00;
            bit_idx            <= 4'h0;
            shift_register     <= BUF_RST;
            transfer_buffer    <= BUF_RST;
            control_register_2 <= CTRL2_RST;
            status_register    <= STAT_RST;
            flags              <= '0;
            push_valid         <= 1'b0;
            sda_out            <= 1'b0;
            sda_oe             <= 1'b0;
            scl_out            <= 1'b0;
            scl_oe             <= 1'b0;
        end else begin
            flags <= flags & ~flag_clear;                                  // [R18] [R24]
            if (cpu_read) begin
                status_register[STAT_BF_BIT] <= 1'b0;                      // [R21]
            end
            if (start_ev) begin
                status_register[STAT_START_BIT] <= 1'b1;                   // [R2] [R9]
            end
            if (step_hit && baud_counter != 7'h00) begin
                baud_counter <= baud_counter - 7'h01;                      // [R23]
            end
            if (fifo_in_ready) begin
                push_valid <= 1'b0;
            end
            // buffer writes outside idle
            if (buf_wr.valid && (in_start || in_rs || in_rx)) begin
                flags.write_collision <= 1'b1;                             // [R5]
            end
            if (buf_wr.valid && in_tx) begin
                flags.write_collision <= 1'b1;                             // [R17]
                if (early_wr) begin
                    transfer_buffer <= buf_wr.data;                        // [R17]
                end
            end
            case (state)
                I2CM_IDLE: begin
                    if (ctl_ok && ctrl2_wr.data[CTRL2_START_BIT]) begin
                        if (sda_f && scl_f) begin
                            control_register_2[CTRL2_START_BIT] <= 1'b1;
                            sda_oe       <= 1'b0;
                            scl_oe       <= 1'b0;
                            baud_counter <= load_hi;                       // [R1]
                            state        <= I2CM_ST_WAIT;
                        end else begin
                            flags.bus_collision_flag <= 1'b1;              // [R4]
                        end
                    end else if (ctl_ok && ctrl2_wr.data[CTRL2_RSTART_BIT]) begin
                        control_register_2[CTRL2_RSTART_BIT] <= 1'b1;      // [R10]
                        scl_oe <= 1'b1;                                    // [R7]
                        state  <= I2CM_RS_SCL_LOW;
                    end else if (ctl_ok && ctrl2_wr.data[CTRL2_RCV_BIT]) begin
                        control_register_2[CTRL2_RCV_BIT] <= 1'b1;         // [R19]
                        scl_oe       <= 1'b1;
                        sda_oe       <= 1'b0;
                        bit_idx      <= 4'h0;
                        baud_counter <= load_hi;
                        state        <= I2CM_RX_LOW;
                    end else if (buf_wr.valid) begin
                        transfer_buffer              <= buf_wr.data;
                        status_register[STAT_BF_BIT] <= 1'b1;              // [R12]
                        baud_counter                 <= load_hi;           // [R12]
                        bit_idx                      <= 4'h0;
                        scl_oe                       <= 1'b1;
                        state                        <= I2CM_TX_LOW;
                    end
                end
                I2CM_ST_WAIT: begin
                    if (!scl_f) begin
                        flags.bus_collision_flag <= 1'b1;                  // [R4]
                        control_register_2[CTRL2_START_BIT] <= 1'b0;
                        state <= I2CM_IDLE;
                    end else if (!sda_f || timeout) begin
                        sda_oe       <= 1'b1;                              // [R1]
                        baud_counter <= load_hi;                           // [R3]
                        state        <= I2CM_ST_HOLD;
                    end
                end
                I2CM_ST_HOLD: begin
                    if (timeout) begin
                        control_register_2[CTRL2_START_BIT] <= 1'b0;       // [R3]
                        flags.module_interrupt_flag <= 1'b1;
                        state <= I2CM_IDLE;
                    end
                end
                I2CM_RS_SCL_LOW: begin
                    if (!scl_f) begin
                        sda_oe       <= 1'b0;                              // [R7]
                        baud_counter <= load_lo;                           // [R7]
                        state        <= I2CM_RS_SDA_REL;
                    end
                end
                I2CM_RS_SDA_REL: begin
                    if (timeout && sda_f) begin
                        scl_oe <= 1'b0;                                    // [R7]
                        state  <= I2CM_RS_RISE;
                    end else if (timeout) begin
                        flags.bus_collision_flag <= 1'b1;
                        control_register_2[CTRL2_RSTART_BIT] <= 1'b0;
                        scl_oe <= 1'b0;
                        state  <= I2CM_IDLE;
                    end
                end
                I2CM_RS_RISE: begin
                    if (scl_f && !sda_f) begin
                        flags.bus_collision_flag <= 1'b1;                  // [R11]
                        control_register_2[CTRL2_RSTART_BIT] <= 1'b0;
                        state <= I2CM_IDLE;
                    end else if (scl_f) begin
                        baud_counter <= load_hi;                           // [R8]
                        state        <= I2CM_RS_HIGH;
                    end
                end
                I2CM_RS_HIGH: begin
                    if (!scl_f || !sda_f) begin
                        flags.bus_collision_flag <= 1'b1;                  // [R11]
                        control_register_2[CTRL2_RSTART_BIT] <= 1'b0;
                        state <= I2CM_IDLE;
                    end else if (timeout) begin
                        sda_oe       <= 1'b1;                              // [R8]
                        baud_counter <= load_hi;
                        state        <= I2CM_RS_SDA_LOW;
                    end
                end
                I2CM_RS_SDA_LOW: begin
                    if (timeout) begin
                        control_register_2[CTRL2_RSTART_BIT] <= 1'b0;      // [R8]
                        flags.module_interrupt_flag <= 1'b1;               // [R9]
                        state <= I2CM_IDLE;
                    end
                end
                I2CM_TX_LOW: begin
                    sda_oe <= (bit_idx == 4'(LAST_TX_BIT)) ? 1'b0 : !tx_bit; // [R13] [R14]
                    if (timeout) begin
                        scl_oe <= 1'b0;                                    // [R13]
                        state  <= I2CM_TX_RISE;
                    end
                end
                I2CM_TX_RISE: begin
                    if (scl_f) begin
                        baud_counter <= load_hi;
                        state        <= I2CM_TX_HIGH;
                    end
                end
                I2CM_TX_HIGH: begin
                    if (timeout) begin
                        scl_oe <= 1'b1;                                    // [R13]
                        if (bit_idx == 4'(LAST_DATA_BIT)) begin
                            status_register[STAT_BF_BIT] <= 1'b0;          // [R14]
                            sda_oe <= 1'b0;                                // [R14]
                        end
                        if (bit_idx == 4'(LAST_TX_BIT)) begin
                            control_register_2[CTRL2_ACKST_BIT] <= sda_f;  // [R15]
                            flags.module_interrupt_flag <= 1'b1;           // [R16]
                            state <= I2CM_IDLE;                            // [R16]
                        end else begin
                            bit_idx      <= bit_idx + 4'h1;
                            baud_counter <= load_hi;
                            state        <= I2CM_TX_LOW;
                        end
                    end
                end
                I2CM_RX_LOW: begin
                    if (timeout) begin
                        scl_oe <= 1'b0;                                    // [R20]
                        state  <= I2CM_RX_RISE;
                    end
                end
                I2CM_RX_RISE: begin
                    if (scl_f) begin
                        baud_counter <= load_hi;
                        state        <= I2CM_RX_HIGH;
                    end
                end
                I2CM_RX_HIGH: begin
                    if (timeout) begin
                        scl_oe         <= 1'b1;                            // [R20]
                        shift_register <= {shift_register[6:0], sda_f};    // [R20]
                        bit_idx        <= bit_idx + 4'h1;
                        baud_counter   <= load_hi;
                        state <= (bit_idx == 4'(LAST_DATA_BIT)) ? I2CM_RX_PUSH : I2CM_RX_LOW;
                    end
                end
                I2CM_RX_PUSH: begin
                    if (fifo_in_ready) begin
                        control_register_2[CTRL2_RCV_BIT] <= 1'b0;         // [R21]
                        transfer_buffer <= shift_register;                 // [R21]
                        push_valid      <= 1'b1;
                        status_register[STAT_BF_BIT] <= 1'b1;              // [R21]
                        flags.module_interrupt_flag  <= 1'b1;              // [R21]
                        if (bf && !cpu_read) begin
                            flags.receive_overflow <= 1'b1;                // [R22]
                        end
                        state <= I2CM_IDLE;
                    end
                end
                default: state <= I2CM_IDLE;
            endcase
        end
    end

    // receive queue
    i2cm_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (transfer_buffer),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );
endmodule // i2cm_top
